// >>> shared/smbus_rx_pkg.sv
// Purpose: Shared constants for the SMBus receive-length block
// Assumes: Special-function register port with 8-bit addresses and data
// Notes: Fill count bits report occupancy of the receive and transmit buffers
package smbus_rx_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RX_LEN_ADDR = 8'hC5;
  localparam logic [7:0] FILL_COUNT_ADDR = 8'hEF;
  localparam logic [7:0] RX_LEN_RESET = 8'h00;
  localparam logic [7:0] FILL_COUNT_RESET = 8'h00;
  localparam int TX_FILL_POS = 4;
  localparam int RX_FILL_POS = 0;

  // ----------------------------------------
  // Link and buffer sizes
  // ----------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] RX_DEPTH = 2'h2;

  typedef enum logic [1:0]
  {
    ST_DATA = 2'b00,
    ST_ACK_LOW = 2'b01,
    ST_ACK_HIGH = 2'b10
  } link_state_e;

endpackage

// >>> rtl/smbus_rx_length_fifo_count.sv
// Purpose: Receive-length counting, stall control and fill count reporting
// Assumes: SCL and SDA arrive asynchronously; byte framing is given by i_rx_active
// Notes: Operation
// Operation
// RULE_01 - Master hw-ack mode uses programmed receive length
// RULE_02 - Count above zero: keep reading and acknowledging
// RULE_03 - Master mode decrements count, stops at zero
// RULE_04 - Byte at zero count: set flag, stall
// RULE_05 - Final byte acknowledged per acknowledge control bit
// RULE_06 - Slave, zero count: stall after every byte
// RULE_07 - Slave, nonzero count: buffer bytes freely
// RULE_08 - Slave mode never decrements the count
// RULE_09 - Firmware changes count only while stalled
// RULE_10 - Read-only fill count, reserved bits zero
// RULE_11 - Threshold request while count exceeds threshold
// RULE_12 - Empty flag while receive buffer empty
`timescale 1ns/100ps
module smbus_rx_length_fifo_count
  import smbus_rx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_master_mode,
  input wire logic i_hw_ack_enable,
  input wire logic i_ack_bit,
  input wire logic i_si_clear,
  input wire logic [1:0] i_rx_threshold,
  input wire logic i_tx_fill_count,
  input wire logic i_rx_active,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_si,
  input wire logic i_rx_pop,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_threshold_request,
  output logic o_rx_empty_flag
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_filt_reg;
  logic sda_filt_reg;
  logic scl_rise;
  logic scl_fall;

  // Edges count only once stages two and three agree
  assign scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_filt_reg;
  assign scl_fall = (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2] && scl_filt_reg;

  // Sync flops reset high, as an idle bus reads
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_filt_reg <= 1'b1;
      sda_filt_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      if (scl_sync_reg[1] == scl_sync_reg[2])
      begin
        scl_filt_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2])
      begin
        sda_filt_reg <= sda_sync_reg[2];
      end
    end
  end

  // ----------------------------------------
  // Link, length counter and flags
  // ----------------------------------------
  link_state_e state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] rx_len_reg, rx_len_next;
  logic ack_reg, ack_next;
  logic hold_reg, hold_next;
  logic pend_reg, pend_next;
  logic si_reg, si_next;
  logic scl_oe_n_reg, scl_oe_n_next;
  logic sda_oe_n_reg, sda_oe_n_next;
  logic byte_done;
  logic counting;
  logic eff_zero;
  logic len_wr;
  logic push;
  logic [1:0] count_reg;

  assign byte_done = (state_reg == ST_DATA) && scl_rise && (bit_cnt_reg == BYTE_BITS - 4'h1);
  assign counting = i_master_mode && i_hw_ack_enable; // see RULE_01
  // Master without hardware ack behaves as a zero count: stall on every byte
  assign eff_zero = (rx_len_reg == 8'h00) || (i_master_mode && !i_hw_ack_enable);
  assign len_wr = i_sfr_wr && (i_sfr_addr == RX_LEN_ADDR);
  // A stall holds the byte until the buffer has room, so nothing is dropped
  assign push = pend_reg && (count_reg != RX_DEPTH);

  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    rx_len_next = rx_len_reg;
    ack_next = ack_reg;
    hold_next = hold_reg;
    pend_next = pend_reg && !push;
    si_next = si_reg && !i_si_clear;
    // Firmware should only write while stalled; a write still takes effect
    if (len_wr)
    begin
      rx_len_next = i_sfr_wdata; // see RULE_09
    end
    if (!i_rx_active)
    begin
      state_next = ST_DATA;
      bit_cnt_next = 4'h0;
      hold_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_DATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_filt_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (byte_done)
          begin
            pend_next = 1'b1;
            if (eff_zero)
            begin
              si_next = 1'b1; // see RULE_04
              hold_next = 1'b1; // see RULE_06
              ack_next = i_ack_bit; // see RULE_05
            end
            else
            begin
              hold_next = 1'b0; // see RULE_07
              ack_next = 1'b1; // see RULE_02
              if (counting && !len_wr)
              begin
                rx_len_next = rx_len_reg - 8'h01; // see RULE_03
              end
            end
          end
          else if (scl_fall && (bit_cnt_reg == BYTE_BITS))
          begin
            state_next = ST_ACK_LOW;
          end
        end
        ST_ACK_LOW:
        begin
          if (scl_rise)
          begin
            state_next = ST_ACK_HIGH;
          end
        end
        ST_ACK_HIGH:
        begin
          if (scl_fall)
          begin
            state_next = ST_DATA;
            bit_cnt_next = 4'h0;
            hold_next = 1'b0;
          end
        end
        default:
        begin
          state_next = ST_DATA;
        end
      endcase
    end
    // Clock held low while the byte waits or the zero-count stall stands
    scl_oe_n_next = !((state_next == ST_ACK_LOW) &&
                      (pend_next || (hold_next && si_next))); // see RULE_06
    sda_oe_n_next = !((state_next != ST_DATA) && ack_next);
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= ST_DATA;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rx_len_reg <= RX_LEN_RESET;
      ack_reg <= 1'b0;
      hold_reg <= 1'b0;
      pend_reg <= 1'b0;
      si_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      rx_len_reg <= rx_len_next;
      ack_reg <= ack_next;
      hold_reg <= hold_next;
      pend_reg <= pend_next;
      si_reg <= si_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
    end
  end

  // ----------------------------------------
  // Two-entry receive buffer
  // ----------------------------------------
  logic [7:0] mem_reg [RX_DEPTH];
  logic [7:0] mem_next [RX_DEPTH];
  logic [1:0] count_next;
  logic pop;
  logic rx_threshold_request_reg;
  logic valid_reg;
  logic empty_reg;

  assign pop = i_rx_pop && (count_reg != 2'h0);

  // Entry zero is always the head, so the data port is a flop
  always_comb
  begin
    mem_next = mem_reg;
    count_next = count_reg;
    if (pop)
    begin
      mem_next[0] = mem_reg[1];
      count_next = count_next - 2'h1;
    end
    if (push)
    begin
      mem_next[count_next[0]] = shift_reg;
      count_next = count_next + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mem_reg[0] <= 8'h00;
      mem_reg[1] <= 8'h00;
      count_reg <= 2'h0;
      rx_threshold_request_reg <= 1'b0;
      valid_reg <= 1'b0;
      empty_reg <= 1'b1;
    end
    else
    begin
      mem_reg <= mem_next;
      count_reg <= count_next;
      valid_reg <= (count_next != 2'h0);
      empty_reg <= (count_next == 2'h0); // see RULE_12
      rx_threshold_request_reg <= (count_next > i_rx_threshold); // see RULE_11
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] fill_val;

  // One-bit fields report whether each buffer holds anything
  always_comb
  begin
    fill_val = FILL_COUNT_RESET;
    fill_val[TX_FILL_POS] = i_tx_fill_count; // see RULE_10
    fill_val[RX_FILL_POS] = (count_reg != 2'h0); // see RULE_10
    rdata_next = rdata_reg;
    if (i_sfr_rd)
    begin
      rdata_next = 8'h00;
      if (i_sfr_addr == RX_LEN_ADDR)
      begin
        rdata_next = rx_len_reg;
      end
      else if (i_sfr_addr == FILL_COUNT_ADDR)
      begin
        rdata_next = fill_val;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign o_sfr_rdata = rdata_reg;
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe_n = scl_oe_n_reg;
  assign o_sda_oe_n = sda_oe_n_reg;
  assign o_si = si_reg;
  assign o_rx_valid = valid_reg;
  assign o_rx_data = mem_reg[0];
  assign o_rx_threshold_request = rx_threshold_request_reg;
  assign o_rx_empty_flag = empty_reg; // see RULE_12

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ACK_COUNTED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_02
    byte_done && counting && rx_len_reg != 8'h00 |=> ack_reg)
    else $error("counted byte not acknowledged");
  AST_DECREMENT: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_03
    byte_done && counting && rx_len_reg != 8'h00 && !len_wr
    |=> rx_len_reg == $past(rx_len_reg) - 8'h01)
    else $error("length not decremented");
  AST_ZERO_STAYS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_03
    rx_len_reg == 8'h00 && !len_wr |=> rx_len_reg == 8'h00)
    else $error("length left zero");
  AST_SI_ON_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_04
    byte_done && eff_zero |=> si_reg && hold_reg)
    else $error("zero count did not flag");
  AST_NAK_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_05
    byte_done && eff_zero && !i_ack_bit |=> !ack_reg ##0 (o_sda_oe_n [*2]))
    else $error("final byte not refused");
  AST_STALL: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_06
    state_reg == ST_ACK_LOW && hold_reg && si_reg && !i_si_clear && i_rx_active
    |=> !o_scl_oe_n)
    else $error("bus not stalled");
  AST_SLAVE_FREE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_07
    byte_done && !i_master_mode && rx_len_reg != 8'h00 |=> !hold_reg)
    else $error("slave stalled on nonzero");
  AST_SLAVE_NODEC: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_08
    byte_done && !i_master_mode && !len_wr |=> $stable(rx_len_reg))
    else $error("slave changed length");
  AST_RESERVED: assert property (@(posedge i_clk) disable iff (!i_reset_n) // see RULE_10
    i_sfr_rd && i_sfr_addr == FILL_COUNT_ADDR
    |=> o_sfr_rdata[7:5] == 3'h0 && o_sfr_rdata[3:1] == 3'h0)
    else $error("reserved bits set");

endmodule // smbus_rx_length_fifo_count

// >>> test/smbus_sender_model.sv
// Purpose: Bus-side sender that clocks bytes into the receiver
// Assumes: Open-drain lines resolved by the bench; 1 = released
// Notes: SCL stands still between frames; stretch waits are bounded
`timescale 1ns/100ps
module smbus_sender_model
(
  input wire logic i_clk,
  input wire logic i_scl_line,
  input wire logic i_sda_line,
  output logic o_scl_drv,
  output logic o_sda_drv
);
  // ----------------------------------------
  // Line handling
  // ----------------------------------------
  initial
  begin
    o_scl_drv = 1'b1;
    o_sda_drv = 1'b1;
  end

  // Release SCL; a stretched clock must not hang the run
  task automatic rise_scl();
    int n;
    o_scl_drv = 1'b1;
    n = 0;
    while (i_scl_line !== 1'b1 && n < 3000)
    begin
      #10;
      n++;
    end
    #40;
  endtask

  // Start: SDA falls while SCL is high
  task automatic start_frame();
    // Step off the clock edge so pin changes never race the sampling flop
    @(posedge i_clk);
    #3;
    o_sda_drv = 1'b0;
    #40;
    o_scl_drv = 1'b0;
    #40;
  endtask

  // Stop: SDA rises while SCL is high
  task automatic stop_frame();
    @(posedge i_clk);
    #3;
    o_sda_drv = 1'b0;
    #40;
    rise_scl();
    o_sda_drv = 1'b1;
    #40;
  endtask

  // Eight bits MSB first, then the ninth clock samples the answer
  task automatic send_byte(input logic [7:0] b, output logic acked);
    @(posedge i_clk);
    #3;
    for (int i = 7; i >= 0; i--)
    begin
      o_sda_drv = b[i];
      #40;
      rise_scl();
      o_scl_drv = 1'b0;
    end
    o_sda_drv = 1'b1;
    // Longer low time: the receiver's stall lands some cycles after the fall
    #60;
    rise_scl();
    acked = ~i_sda_line;
    o_scl_drv = 1'b0;
    #40;
  endtask
endmodule // smbus_sender_model

// >>> test/smbus_rx_length_fifo_count_bench.sv
// Purpose: Self-checking bench for receive length and fill count
// Assumes: Sender model on the bus; bench services the buffer
// Notes: Pins pass one flop before the block inputs
`timescale 1ns/100ps
module smbus_rx_length_fifo_count_bench;
  import smbus_rx_pkg::*;
  logic clk, reset_n, sfr_wr, sfr_rd, master_mode, hw_ack, ack_bit, si_clear;
  logic tx_fill, rx_active, scl_in, sda_in, scl_oe_n, sda_oe_n, si, si_d, rx_pop;
  logic rx_valid, rx_req, rx_empty, scl_drv, sda_drv, auto_pop, stall_seen, a;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_data;
  logic [1:0] rx_threshold;
  logic [7:0] got_q[$];
  logic [7:0] exp_q[$] = '{8'hA5, 8'h3C, 8'hF0, 8'h11, 8'h22, 8'h33, 8'h44};
  int n_fail, checks_done, si_rises, cycles;
  wire scl_line = scl_drv & scl_oe_n;
  wire sda_line = sda_drv & sda_oe_n;

  smbus_rx_length_fifo_count smbus_rx_length_fifo_count_i (.i_clk(clk), .i_reset_n(reset_n),
    .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
    .o_sfr_rdata(sfr_rdata), .i_master_mode(master_mode), .i_hw_ack_enable(hw_ack),
    .i_ack_bit(ack_bit), .i_si_clear(si_clear), .i_rx_threshold(rx_threshold),
    .i_tx_fill_count(tx_fill), .i_rx_active(rx_active), .i_scl(scl_in), .i_sda(sda_in),
    .o_scl_out(), .o_scl_oe_n(scl_oe_n), .o_sda_out(), .o_sda_oe_n(sda_oe_n), .o_si(si),
    .i_rx_pop(rx_pop), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_threshold_request(rx_req), .o_rx_empty_flag(rx_empty));
  smbus_sender_model smbus_sender_model_i (.i_clk(clk), .i_scl_line(scl_line),
    .i_sda_line(sda_line),
    .o_scl_drv(scl_drv), .o_sda_drv(sda_drv));

  // ----------------------------------------
  // Compare, report and register tasks
  // ----------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk) {sfr_addr, sfr_wdata, sfr_wr} <= {ad, d, 1'b1};
    @(posedge clk) sfr_wr <= 1'b0;
  endtask
  // Read data lands one cycle after the strobe is taken
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk) {sfr_addr, sfr_rd} <= {ad, 1'b1};
    @(posedge clk) sfr_rd <= 1'b0;
    #1 check_byte(sfr_rdata, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rd(RX_LEN_ADDR, RX_LEN_RESET);
    wr(FILL_COUNT_ADDR, 8'hFF);
    rd(FILL_COUNT_ADDR, FILL_COUNT_RESET);
    rd(8'h00, 8'h00);
    check_bit(rx_empty, 1'b1);
  endtask

  // Count 2: two bytes acked and counted down, third stalls and is refused
  task automatic test_master();
    wr(RX_LEN_ADDR, 8'h02);
    @(posedge clk) {master_mode, hw_ack, ack_bit, rx_active} <= 4'hD;
    smbus_sender_model_i.start_frame();
    smbus_sender_model_i.send_byte(8'hA5, a);
    check_bit(a, 1'b1);
    rd(RX_LEN_ADDR, 8'h01);
    smbus_sender_model_i.send_byte(8'h3C, a);
    check_bit(a, 1'b1);
    rd(RX_LEN_ADDR, 8'h00);
    check_bit(stall_seen, 1'b0);
    smbus_sender_model_i.send_byte(8'hF0, a);
    check_bit(a, 1'b0);
    rd(RX_LEN_ADDR, 8'h00);
    check_byte(8'(si_rises), 8'h01);
    check_bit(stall_seen, 1'b1);
    @(posedge clk) rx_active <= 1'b0;
    smbus_sender_model_i.stop_frame();
  endtask

  // Slave: zero count stalls each byte; nonzero count buffers, never counts
  task automatic test_slave();
    @(posedge clk) {master_mode, ack_bit, rx_active} <= 3'b011;
    wr(RX_LEN_ADDR, 8'h00);
    smbus_sender_model_i.start_frame();
    smbus_sender_model_i.send_byte(8'h11, a);
    check_bit(a, 1'b1);
    smbus_sender_model_i.send_byte(8'h22, a);
    check_byte(8'(si_rises), 8'h02);
    check_bit(stall_seen, 1'b1);
    @(posedge clk) rx_active <= 1'b0;
    smbus_sender_model_i.stop_frame();
    @(posedge clk) {auto_pop, rx_active} <= 2'b01;
    wr(RX_LEN_ADDR, 8'h05);
    smbus_sender_model_i.start_frame();
    smbus_sender_model_i.send_byte(8'h33, a);
    smbus_sender_model_i.send_byte(8'h44, a);
    check_bit(a, 1'b1);
    check_byte(8'(si_rises), 8'h00);
    rd(RX_LEN_ADDR, 8'h05);
    @(posedge clk) {tx_fill, rx_threshold} <= 3'b101;
    repeat (3) @(posedge clk);
    check_bit(rx_req, 1'b1);
    check_bit(rx_empty, 1'b0);
    rd(FILL_COUNT_ADDR, 8'h11);
    @(posedge clk) rx_threshold <= 2'h2;
    repeat (3) @(posedge clk);
    check_bit(rx_req, 1'b0);
    @(posedge clk) {auto_pop, rx_active} <= 2'b10;
    smbus_sender_model_i.stop_frame();
    repeat (8) @(posedge clk);
    check_bit(rx_empty, 1'b1);
    rd(FILL_COUNT_ADDR, 8'h10);
    check_byte(8'(got_q.size()), 8'h07);
    foreach (exp_q[i]) check_byte(got_q[i], exp_q[i]);
  endtask

  // ----------------------------------------
  // Clock, pins, buffer service and timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Flag clear and pop are pulses; firmware clears the flag only once stalled
  // Stall and flag tallies restart while no frame is under way
  always @(posedge clk)
  begin
    {scl_in, sda_in, si_d} <= {scl_line, sda_line, si};
    si_rises = rx_active ? si_rises + int'(si === 1'b1 && si_d !== 1'b1) : 0;
    stall_seen <= rx_active & (stall_seen | (scl_oe_n === 1'b0));
    si_clear <= (si === 1'b1) & (scl_oe_n === 1'b0) & ~si_clear;
    rx_pop <= auto_pop & (rx_valid === 1'b1) & ~rx_pop;
    if (auto_pop && rx_valid === 1'b1 && !rx_pop)
      got_q.push_back(rx_data);
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  // Main sequence
  initial
  begin
    {reset_n, sfr_wr, sfr_rd, master_mode, hw_ack, ack_bit, si_clear} = 7'h00;
    {tx_fill, rx_active, scl_in, sda_in, rx_pop, si_d, stall_seen} = 7'h18;
    {sfr_addr, sfr_wdata, rx_threshold, auto_pop} = 19'h00001;
    n_fail = 0;
    checks_done = 0;
    si_rises = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_master();
    test_slave();
    give_verdict();
  end
endmodule // smbus_rx_length_fifo_count_bench
